//--- evd_dec_if.sv
// Carrier between the dispatcher and its vector decoder
`timescale 1ns/1ps
interface evd_dec_if;
  evd_pkg::evd_evt_t ev; // Event to look up
  logic [31:0] ofs;      // Vector offset
  logic [3:0] nparams;   // Parameters pushed
  logic is_exc;          // Exception, not interrupt
  logic [4:0] interrupt_priority_level;       // Interrupt level of an interrupt
  logic force_int;       // Must run on interrupt stack
  logic valid;           // Event has a vector here
  modport req (output ev, input ofs, nparams, is_exc, interrupt_priority_level, force_int, valid);
  modport dec (input ev, output ofs, nparams, is_exc, interrupt_priority_level, force_int, valid);
endinterface

//--- evd_dispatch.sv
// Vector table dispatcher: base register, fetch, decode, status
//
// Overview of operation
// [RL1] Full 32-bit base locates vector table
// [RL2] Base write clears the two low bits
// [RL3] Software should page-align the base
// [RL4] 30-bit mode ignores base top bits
// [RL5] Each event fetches one aligned vector
// [RL6] Vector high bits give aligned handler
// [RL7] Code 00: kernel stack unless interrupt stack
// [RL8] Code 01: interrupt stack, exceptions raise level
// [RL9] Codes 10, 11 force console error halt
// [RL10] Machine check: offset 04, six parameters
// [RL11] Bad kernel stack: offset 08, none
// [RL12] Access 20, translation 24, two parameters
// [RL13] Arithmetic: offset 34, one type code
// [RL14] Change mode traps 40 to 4C
// [RL15] Offset 30 is never dispatched
// [RL16] Device requests use D0 to DC
// [RL17] System error: offset 60, level 1D
// [RL18] Fetch address is masked base plus offset
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module evd_dispatch (
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Event requests
  input wire logic exc_req,
  input wire logic [3:0] exc_code,
  input wire logic [31:0] exc_param0,
  input wire logic [31:0] exc_param1,
  input wire logic [3:0] irq_req,
  input wire logic sys_err,
  input wire logic on_int_stack,
  // Vector memory read port
  output logic mem_rd_req,
  output logic [31:0] mem_addr,
  input wire logic mem_rd_valid,
  input wire logic [31:0] mem_rd_data,
  // Dispatch result
  output logic busy,
  output logic disp_valid,
  output logic disp_halt,
  output logic [31:0] disp_handler,
  output logic disp_int_stack,
  output logic disp_ipl_load,
  output logic [4:0] disp_ipl,
  output logic [3:0] disp_nparams,
  output logic [31:0] disp_param0,
  output logic [31:0] disp_param1,
  output logic irq
);
  evd_dec_if dif (); // Lookup carrier
  evd_pkg::evd_state_t state_reg; // Sequencer state
  logic [31:0] vtb_reg; // Table base
  logic addr30_reg; // 30-bit physical mode
  logic [evd_pkg::ST_W-1:0] stat_reg; // Sticky events
  logic [evd_pkg::ST_W-1:0] stat_next;
  logic [evd_pkg::ST_W-1:0] mask_reg; // Interrupt mask
  logic [evd_pkg::ST_W-1:0] ev_set; // Events this cycle
  logic [31:0] base_eff; // Masked base
  evd_pkg::evd_evt_t sel_ev; // Chosen event
  logic sel_req; // Some event pending
  logic take; // Event accepted
  evd_pkg::evd_evt_t ev_lat_reg; // Event in flight
  logic exc_lat_reg; // In-flight is exception
  logic force_lat_reg; // In-flight forces int stack
  logic [4:0] ipl_lat_reg; // In-flight interrupt level
  logic [3:0] np_lat_reg; // In-flight parameter count
  logic [31:0] p0_lat_reg; // Captured first parameter
  logic [31:0] p1_lat_reg; // Captured second parameter
  logic vec_back; // Vector word arrives
  logic [31:0] p0_ext; // Sign-extended operand word

  // Vector lookup
  evd_vec_decode u_dec (
    .dif(dif)
  );

  // Pick event: exceptions, then system error, then highest device
  always_comb begin
    sel_ev = evd_pkg::EV_NONE;
    sel_req = 1'b0;
    for (int i = 0; i < evd_pkg::NDEV; i++) begin
      if (irq_req[i]) begin
        sel_ev = evd_pkg::evd_evt_t'(evd_pkg::EV_DEV0 + 4'(i));
        sel_req = 1'b1;
      end
    end
    if (sys_err) begin
      sel_ev = evd_pkg::EV_SYSERR;
      sel_req = 1'b1;
    end
    if (exc_req) begin
      sel_ev = evd_pkg::evd_evt_t'(exc_code);
      sel_req = 1'b1;
    end
  end
  assign dif.ev = sel_ev;
  assign take = sel_req && state_reg == evd_pkg::S_IDLE;
  assign vec_back = state_reg == evd_pkg::S_FETCH && mem_rd_valid;

  // [RL4] Drop top bits in 30-bit mode
  assign base_eff = addr30_reg ? (vtb_reg & evd_pkg::ADDR30_MASK) : vtb_reg;

  // Sign extension of the change-mode operand word
  assign p0_ext = {{(32 - evd_pkg::SEXT_W){p0_lat_reg[evd_pkg::SEXT_W-1]}},
    p0_lat_reg[evd_pkg::SEXT_W-1:0]};

  // Base and control registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vtb_reg <= evd_pkg::VTB_RST;
      addr30_reg <= 1'b0;
      mask_reg <= evd_pkg::ST_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        // [RL1] [RL2] Full address, low bits cleared
        evd_pkg::REG_VTB: vtb_reg <= reg_wdata & evd_pkg::ALIGN_MASK;
        evd_pkg::REG_CTRL: addr30_reg <= reg_wdata[evd_pkg::CTRL_ADDR30];
        evd_pkg::REG_MASK: mask_reg <= reg_wdata[evd_pkg::ST_W-1:0];
        // Read-only or unmapped
        default: begin
        end
      endcase
    end
  end

  // Sequencer and vector fetch
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= evd_pkg::S_IDLE;
      mem_rd_req <= 1'b0;
      mem_addr <= evd_pkg::VTB_RST;
      busy <= 1'b0;
    end else begin
      case (state_reg)
        evd_pkg::S_IDLE: begin
          // [RL5] [RL18] Fetch the event vector
          if (take && dif.valid) begin
            state_reg <= evd_pkg::S_FETCH;
            mem_rd_req <= 1'b1;
            mem_addr <= base_eff + dif.ofs;
            busy <= 1'b1;
          end
        end
        evd_pkg::S_FETCH: begin
          // Hold request until the word returns
          if (mem_rd_valid) begin
            state_reg <= evd_pkg::S_IDLE;
            mem_rd_req <= 1'b0;
            busy <= 1'b0;
          end
        end
        default: begin
          state_reg <= evd_pkg::S_IDLE;
          mem_rd_req <= 1'b0;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Capture of the event in flight
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ev_lat_reg <= evd_pkg::EV_NONE;
      exc_lat_reg <= 1'b0;
      force_lat_reg <= 1'b0;
      ipl_lat_reg <= evd_pkg::IPL_ZERO;
      np_lat_reg <= evd_pkg::NP_NONE;
      p0_lat_reg <= evd_pkg::VTB_RST;
      p1_lat_reg <= evd_pkg::VTB_RST;
    end else if (take && dif.valid) begin
      ev_lat_reg <= sel_ev;
      exc_lat_reg <= dif.is_exc;
      force_lat_reg <= dif.force_int;
      ipl_lat_reg <= dif.interrupt_priority_level;
      np_lat_reg <= dif.nparams;
      p0_lat_reg <= exc_param0;
      p1_lat_reg <= exc_param1;
    end
  end

  // Result from the returned vector
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      disp_valid <= 1'b0;
      disp_halt <= 1'b0;
      disp_handler <= evd_pkg::VTB_RST;
      disp_int_stack <= 1'b0;
      disp_ipl_load <= 1'b0;
      disp_ipl <= evd_pkg::IPL_ZERO;
      disp_nparams <= evd_pkg::NP_NONE;
      disp_param0 <= evd_pkg::VTB_RST;
      disp_param1 <= evd_pkg::VTB_RST;
    end else begin
      disp_valid <= 1'b0;
      disp_halt <= 1'b0;
      if (vec_back) begin
        // [RL9] Codes 10 and 11 halt instead
        if (mem_rd_data[evd_pkg::VC_HALT_BIT]) begin
          disp_halt <= 1'b1;
        end else begin
          disp_valid <= 1'b1;
        end
        // [RL6] Handler is longword aligned
        disp_handler <= mem_rd_data & evd_pkg::ALIGN_MASK;
        // [RL7] [RL8] Stack choice
        disp_int_stack <= force_lat_reg || on_int_stack ||
          mem_rd_data[1:0] == evd_pkg::VC_INTSTK;
        // [RL8] Exceptions on code 01 go to top level
        if (exc_lat_reg) begin
          disp_ipl_load <= mem_rd_data[1:0] == evd_pkg::VC_INTSTK;
          disp_ipl <= evd_pkg::IPL_HIGH;
        end else begin
          disp_ipl_load <= 1'b1;
          disp_ipl <= ipl_lat_reg;
        end
        disp_nparams <= np_lat_reg;
        // [RL14] Change mode operand is sign extended
        if (ev_lat_reg >= evd_pkg::EV_TO_KERN &&
            ev_lat_reg <= evd_pkg::EV_TO_USER) begin
          disp_param0 <= p0_ext;
        end else begin
          disp_param0 <= p0_lat_reg;
        end
        disp_param1 <= p1_lat_reg;
      end
    end
  end

  // Sticky event sources
  always_comb begin
    ev_set = evd_pkg::ST_RST;
    ev_set[evd_pkg::ST_DISP] = vec_back &&
      !mem_rd_data[evd_pkg::VC_HALT_BIT];
    ev_set[evd_pkg::ST_HALT] = vec_back &&
      mem_rd_data[evd_pkg::VC_HALT_BIT];
    // [RL15] Refused events are flagged
    ev_set[evd_pkg::ST_REJ] = take && !dif.valid;
  end

  // Clear on status read, a new event wins
  always_comb begin
    stat_next = stat_reg;
    if (reg_rd && reg_addr == evd_pkg::REG_STAT) begin
      stat_next = evd_pkg::ST_RST;
    end
    stat_next = stat_next | ev_set;
  end

  // Status and interrupt line
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= evd_pkg::ST_RST;
      irq <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq <= |(stat_next & mask_reg);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= evd_pkg::VTB_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        evd_pkg::REG_VTB: reg_rdata <= vtb_reg;
        evd_pkg::REG_CTRL: reg_rdata <= 32'(addr30_reg);
        evd_pkg::REG_STAT: reg_rdata <= 32'(stat_reg);
        evd_pkg::REG_MASK: reg_rdata <= 32'(mask_reg);
        evd_pkg::REG_HNDL: reg_rdata <= disp_handler;
        default: reg_rdata <= evd_pkg::VTB_RST;
      endcase
    end else begin
      reg_rdata <= evd_pkg::VTB_RST;
    end
  end

  a_base_clear: assert property ( // [RL2]
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && reg_addr == evd_pkg::REG_VTB |=>
      vtb_reg == ($past(reg_wdata) & evd_pkg::ALIGN_MASK))
    else $error("Base low bits not cleared");

  a_fetch_addr: assert property ( // [RL18]
    @(posedge clk_sys) disable iff (!nrst)
    take && dif.valid && addr30_reg |=>
      mem_rd_req && mem_addr == (($past(vtb_reg) & evd_pkg::ADDR30_MASK)
      + $past(dif.ofs)))
    else $error("Fetch address wrong in 30-bit mode");

  a_handler_word: assert property ( // [RL6]
    @(posedge clk_sys) disable iff (!nrst)
    vec_back |=> disp_handler[31:2] == $past(mem_rd_data[31:2]) &&
      disp_handler[1:0] == 2'b00)
    else $error("Handler address not taken from vector");

  a_halt_code: assert property ( // [RL9]
    @(posedge clk_sys) disable iff (!nrst)
    vec_back && mem_rd_data[1] |=> disp_halt && !disp_valid)
    else $error("Halt code dispatched");

  a_kernel_stack: assert property ( // [RL7]
    @(posedge clk_sys) disable iff (!nrst)
    vec_back && mem_rd_data[1:0] == 2'b00 && !force_lat_reg &&
      !on_int_stack |=> disp_valid && !disp_int_stack)
    else $error("Code 00 left kernel stack");

  a_exc_raise: assert property ( // [RL8]
    @(posedge clk_sys) disable iff (!nrst)
    vec_back && mem_rd_data[1:0] == 2'b01 && exc_lat_reg |=>
      disp_int_stack && disp_ipl_load && disp_ipl == 5'h1f)
    else $error("Exception on code 01 not raised");

  a_compat_skip: assert property ( // [RL15]
    @(posedge clk_sys) disable iff (!nrst)
    take && sel_ev == evd_pkg::EV_COMPAT |=>
      !mem_rd_req && stat_reg[evd_pkg::ST_REJ])
    else $error("Compatibility slot dispatched");

  a_mchk_frame: assert property ( // [RL10]
    @(posedge clk_sys) disable iff (!nrst)
    disp_valid && ev_lat_reg == evd_pkg::EV_MCHK |->
      disp_nparams == 4'h6 && disp_int_stack)
    else $error("Machine check frame wrong");

  a_dev_level: assert property ( // [RL16]
    @(posedge clk_sys) disable iff (!nrst)
    vec_back && ev_lat_reg == evd_pkg::EV_DEV3 |=>
      disp_ipl == 5'h17 && disp_ipl_load)
    else $error("Device level wrong");
endmodule // evd_dispatch

//--- evd_pkg.sv
// Constants, encodings and register map of the vector dispatch block
package evd_pkg;
  // Event identities presented to the vector decoder
  typedef enum logic [3:0] {
    EV_NONE   = 4'h0,
    EV_MCHK   = 4'h1,
    EV_KSNV   = 4'h2,
    EV_ACV    = 4'h3,
    EV_TNV    = 4'h4,
    EV_COMPAT = 4'h5,
    EV_ARITH  = 4'h6,
    EV_TO_KERN = 4'h7,
    EV_TO_EXEC = 4'h8,
    EV_TO_SUPV = 4'h9,
    EV_TO_USER = 4'ha,
    EV_SYSERR = 4'hb,
    EV_DEV0   = 4'hc,
    EV_DEV1   = 4'hd,
    EV_DEV2   = 4'he,
    EV_DEV3   = 4'hf
  } evd_evt_t;

  // Dispatch sequencer states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01
  } evd_state_t;

  // Vector offsets within the table
  localparam logic [31:0] OFS_MCHK = 32'h0000_0004;
  localparam logic [31:0] OFS_KSNV = 32'h0000_0008;
  localparam logic [31:0] OFS_ACV = 32'h0000_0020;
  localparam logic [31:0] OFS_TNV = 32'h0000_0024;
  localparam logic [31:0] OFS_COMPAT = 32'h0000_0030;
  localparam logic [31:0] OFS_ARITH = 32'h0000_0034;
  localparam logic [31:0] OFS_TO_KERN = 32'h0000_0040;
  localparam logic [31:0] OFS_TO_EXEC = 32'h0000_0044;
  localparam logic [31:0] OFS_TO_SUPV = 32'h0000_0048;
  localparam logic [31:0] OFS_TO_USER = 32'h0000_004c;
  localparam logic [31:0] OFS_SYSERR = 32'h0000_0060;
  localparam logic [31:0] OFS_DEV0 = 32'h0000_00d0;
  localparam logic [31:0] OFS_DEV1 = 32'h0000_00d4;
  localparam logic [31:0] OFS_DEV2 = 32'h0000_00d8;
  localparam logic [31:0] OFS_DEV3 = 32'h0000_00dc;

  // Parameter counts pushed per event
  localparam logic [3:0] NP_MCHK = 4'h6;
  localparam logic [3:0] NP_NONE = 4'h0;
  localparam logic [3:0] NP_FAULT = 4'h2;
  localparam logic [3:0] NP_ONE = 4'h1;

  // Priority levels
  localparam logic [4:0] IPL_HIGH = 5'h1f;
  localparam logic [4:0] IPL_SYSERR = 5'h1d;
  localparam logic [4:0] IPL_DEV0 = 5'h14;
  localparam logic [4:0] IPL_DEV1 = 5'h15;
  localparam logic [4:0] IPL_DEV2 = 5'h16;
  localparam logic [4:0] IPL_DEV3 = 5'h17;
  localparam logic [4:0] IPL_ZERO = 5'h00;

  // Vector low-bit codes
  localparam logic [1:0] VC_KERNEL = 2'b00;
  localparam logic [1:0] VC_INTSTK = 2'b01;
  localparam int VC_HALT_BIT = 1;

  // Address masks
  localparam logic [31:0] ALIGN_MASK = 32'hffff_fffc;
  localparam logic [31:0] ADDR30_MASK = 32'h3fff_ffff;

  // Register map, byte addresses
  localparam logic [7:0] REG_VTB = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_HNDL = 8'h10;

  // Field positions and widths
  localparam int CTRL_ADDR30 = 0;
  localparam int ST_W = 3;
  localparam int ST_DISP = 0;
  localparam int ST_HALT = 1;
  localparam int ST_REJ = 2;
  localparam int NDEV = 4;
  localparam int SEXT_W = 16;

  // Reset values
  localparam logic [31:0] VTB_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;
endpackage

//--- evd_vec_decode.sv
// Event to vector offset, type and parameter count lookup
`timescale 1ns/1ps
module evd_vec_decode (
  evd_dec_if.dec dif
);
  // Idle offset value when nothing matches
  localparam logic [31:0] OFS_DEV0_Z = 32'h0000_0000;

  // Table of assignments
  always_comb begin
    dif.ofs = OFS_DEV0_Z;
    dif.nparams = evd_pkg::NP_NONE;
    dif.is_exc = 1'b1;
    dif.interrupt_priority_level = evd_pkg::IPL_ZERO;
    dif.force_int = 1'b0;
    dif.valid = 1'b1;
    case (dif.ev)
      // [RL10] Machine check entry
      evd_pkg::EV_MCHK: begin
        dif.ofs = evd_pkg::OFS_MCHK;
        dif.nparams = evd_pkg::NP_MCHK;
        dif.force_int = 1'b1;
      end
      // [RL11] Bad kernel stack
      evd_pkg::EV_KSNV: begin
        dif.ofs = evd_pkg::OFS_KSNV;
        dif.force_int = 1'b1;
      end
      // [RL12] Access and translation faults
      evd_pkg::EV_ACV: begin
        dif.ofs = evd_pkg::OFS_ACV;
        dif.nparams = evd_pkg::NP_FAULT;
      end
      evd_pkg::EV_TNV: begin
        dif.ofs = evd_pkg::OFS_TNV;
        dif.nparams = evd_pkg::NP_FAULT;
      end
      // [RL13] Arithmetic type code
      evd_pkg::EV_ARITH: begin
        dif.ofs = evd_pkg::OFS_ARITH;
        dif.nparams = evd_pkg::NP_ONE;
      end
      // [RL14] Change mode traps
      evd_pkg::EV_TO_KERN: begin
        dif.ofs = evd_pkg::OFS_TO_KERN;
        dif.nparams = evd_pkg::NP_ONE;
      end
      evd_pkg::EV_TO_EXEC: begin
        dif.ofs = evd_pkg::OFS_TO_EXEC;
        dif.nparams = evd_pkg::NP_ONE;
      end
      evd_pkg::EV_TO_SUPV: begin
        dif.ofs = evd_pkg::OFS_TO_SUPV;
        dif.nparams = evd_pkg::NP_ONE;
      end
      evd_pkg::EV_TO_USER: begin
        dif.ofs = evd_pkg::OFS_TO_USER;
        dif.nparams = evd_pkg::NP_ONE;
      end
      // [RL17] System error interrupt
      evd_pkg::EV_SYSERR: begin
        dif.ofs = evd_pkg::OFS_SYSERR;
        dif.is_exc = 1'b0;
        dif.interrupt_priority_level = evd_pkg::IPL_SYSERR;
      end
      // [RL16] Device interrupt vectors
      evd_pkg::EV_DEV0: begin
        dif.ofs = evd_pkg::OFS_DEV0;
        dif.is_exc = 1'b0;
        dif.interrupt_priority_level = evd_pkg::IPL_DEV0;
      end
      evd_pkg::EV_DEV1: begin
        dif.ofs = evd_pkg::OFS_DEV1;
        dif.is_exc = 1'b0;
        dif.interrupt_priority_level = evd_pkg::IPL_DEV1;
      end
      evd_pkg::EV_DEV2: begin
        dif.ofs = evd_pkg::OFS_DEV2;
        dif.is_exc = 1'b0;
        dif.interrupt_priority_level = evd_pkg::IPL_DEV2;
      end
      evd_pkg::EV_DEV3: begin
        dif.ofs = evd_pkg::OFS_DEV3;
        dif.is_exc = 1'b0;
        dif.interrupt_priority_level = evd_pkg::IPL_DEV3;
      end
      // [RL15] Compatibility slot has no vector
      evd_pkg::EV_COMPAT: begin
        dif.ofs = evd_pkg::OFS_COMPAT;
        dif.valid = 1'b0;
      end
      // No event or unknown code
      default: begin
        dif.valid = 1'b0;
      end
    endcase
  end

endmodule // evd_vec_decode

//--- evd_vec_mem.sv
// Behavioural vector table memory answering the dispatcher's fetches
`timescale 1ns/1ps
module evd_vec_mem (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_lat,
  input wire logic [1:0] vec_low,
  output logic mem_rd_valid,
  output logic [31:0] mem_rd_data
);
  logic [1:0] wait_reg; // Idle cycles spent on this fetch
  logic [31:0] word_reg; // Word of the last answer

  // One answer pulse per fetch, after mem_lat extra cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_rd_valid <= 1'b0;
      wait_reg <= 2'h0;
      word_reg <= 32'h0000_0000;
    end else begin
      mem_rd_valid <= 1'b0;
      if (mem_rd_req && !mem_rd_valid) begin
        if (wait_reg == mem_lat) begin
          mem_rd_valid <= 1'b1;
          wait_reg <= 2'h0;
          // Aligned longword, low address bits unused
          word_reg <= {mem_addr[31:2] ^ 30'h2aaa_5555, vec_low};
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end

  // Outside the answer the line shows the inverse of the last word
  assign mem_rd_data = mem_rd_valid ? word_reg : ~word_reg;
endmodule // evd_vec_mem

//--- tb_evd_dispatch.sv
// Self-checking testbench of the vector dispatch block
`timescale 1ns/1ps
module tb_evd_dispatch;
  logic clk_sys, nrst, reg_wr, reg_rd, exc_req, sys_err, on_int_stack;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, exc_param0, exc_param1, mem_addr;
  logic [3:0] exc_code, irq_req, disp_nparams;
  logic mem_rd_req, mem_rd_valid, busy, disp_valid, disp_halt, irq;
  logic disp_int_stack, disp_ipl_load;
  logic [31:0] mem_rd_data, disp_handler, disp_param0, disp_param1;
  logic [4:0] disp_ipl;
  logic [1:0] mem_lat, vec_low; // Memory latency and vector code
  logic [31:0] base, last_h; // Programmed base, last handler
  logic a30; // 30-bit mode selected
  int errors, check_count, cyc;
  logic [3:0] codes [14] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8,
    4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf}; // Events with a vector

  evd_dispatch i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .exc_req(exc_req), .exc_code(exc_code),
    .exc_param0(exc_param0), .exc_param1(exc_param1), .irq_req(irq_req),
    .sys_err(sys_err), .on_int_stack(on_int_stack),
    .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .busy(busy),
    .disp_valid(disp_valid), .disp_halt(disp_halt),
    .disp_handler(disp_handler), .disp_int_stack(disp_int_stack),
    .disp_ipl_load(disp_ipl_load), .disp_ipl(disp_ipl),
    .disp_nparams(disp_nparams), .disp_param0(disp_param0),
    .disp_param1(disp_param1), .irq(irq));

  evd_vec_mem i_mem (.clk_sys(clk_sys), .nrst(nrst),
    .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_lat(mem_lat),
    .vec_low(vec_low), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Raise one event, follow its fetch and check the result
  task automatic run_ev(input logic [3:0] c, input logic [1:0] lc,
      input logic stk);
    logic [31:0] ofs, ea, p0e;
    logic [3:0] np;
    logic [4:0] lvl;
    logic exc, frc;
    int n;
    exc = 1'b1;
    frc = 1'b0;
    lvl = 5'h00;
    np = 4'h1;
    p0e = 32'h1234_8001;
    case (c)
      4'h1: begin ofs = 32'h04; np = 4'h6; frc = 1'b1; end
      4'h2: begin ofs = 32'h08; np = 4'h0; frc = 1'b1; end
      4'h3: begin ofs = 32'h20; np = 4'h2; end
      4'h4: begin ofs = 32'h24; np = 4'h2; end
      4'h6: ofs = 32'h34;
      4'hb: begin ofs = 32'h60; np = 4'h0; exc = 1'b0; lvl = 5'h1d; end
      4'hc, 4'hd, 4'he, 4'hf: begin
        ofs = 32'hd0 + {28'h0, c[1:0], 2'b00};
        np = 4'h0;
        exc = 1'b0;
        lvl = 5'h14 + {3'h0, c[1:0]};
      end
      default: begin
        ofs = 32'h40 + {28'h0, c[1:0] - 2'h3, 2'b00};
        p0e = 32'hffff_8001;
      end
    endcase
    ea = (base & (a30 ? 32'h3fff_ffff : 32'hffff_ffff)) + ofs;
    @(posedge clk_sys);
    vec_low <= lc;
    on_int_stack <= stk;
    mem_lat <= c[1:0];
    if (exc) begin
      exc_req <= 1'b1;
      exc_code <= c;
    end else if (c == 4'hb) sys_err <= 1'b1;
    else irq_req <= 4'h1 << c[1:0];
    @(posedge clk_sys);
    exc_req <= 1'b0;
    sys_err <= 1'b0;
    irq_req <= 4'h0;
    #1;
    chk(mem_rd_req, 1'b1);
    chk(busy, 1'b1);
    chk(mem_addr, ea);
    n = 0;
    while (disp_valid !== 1'b1 && disp_halt !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    last_h = {ea[31:2] ^ 30'h2aaa_5555, 2'b00};
    chk(disp_halt, lc[1]);
    chk(disp_valid, !lc[1]);
    chk(busy, 1'b0);
    if (!lc[1]) begin
      chk(disp_handler, last_h);
      chk(disp_int_stack, lc[0] | stk | frc);
      chk(disp_ipl_load, lc[0] | !exc);
      if (lc[0] | !exc) chk(disp_ipl, exc ? 5'h1f : lvl);
      chk(disp_nparams, np);
      if (exc) chk(disp_param0, p0e);
      if (np == 4'h2) chk(disp_param1, 32'h0000_00a5);
    end
  endtask

  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, exc_req, sys_err, on_int_stack} = 6'h00;
    {reg_addr, reg_wdata, exc_code, irq_req} = 48'h0;
    exc_param0 = 32'h1234_8001;
    exc_param1 = 32'h0000_00a5;
    {mem_lat, vec_low, a30} = 5'h00;
    {errors, check_count, cyc} = 96'h0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(8'h00, 32'hc000_1233);
    rd(8'h00, 32'hc000_1230);
    base = 32'hc000_1200;
    wr(8'h00, base);
    wr(8'h0c, 32'h0000_0007);
    // Every event with a vector under every vector code, and under code 00 on the interrupt stack
    for (int lc = 0; lc < 5; lc++) begin
      for (int k = 0; k < 14; k++) begin
        run_ev(codes[k], (lc == 4) ? 2'b00 : 2'(lc), lc == 4);
      end
    end
    chk(irq, 1'b1);
    rd(8'h08, 32'h0000_0003);
    rd(8'h08, 32'h0000_0000);
    chk(irq, 1'b0);
    // Offset 30 event is refused, masked status stays quiet
    wr(8'h0c, 32'h0000_0000);
    @(posedge clk_sys);
    exc_req <= 1'b1;
    exc_code <= 4'h5;
    @(posedge clk_sys);
    exc_req <= 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      chk(mem_rd_req, 1'b0);
    end
    chk(irq, 1'b0);
    rd(8'h08, 32'h0000_0004);
    // Narrow address mode drops the top base bits
    wr(8'h04, 32'h0000_0001);
    a30 = 1'b1;
    run_ev(4'h1, 2'b01, 1'b0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, last_h);
    give_verdict();
  end
endmodule // tb_evd_dispatch
